// >>> hw/clp_pkg.sv
// Package with the constants of the cold load pickup block.
// Notes on behaviour
// - Four modes: open, undercurrent, both, either.
// - Cold transition starts the load-off timer.
// - Load-off expiry raises cold load active.
// - Cold end arms the inrush detector.
// - Inrush when current exceeds inrush threshold.
// - Inrush ends at ninety percent of threshold.
// - Inrush end starts the settle timer.
// - Active falls after settle expiry, after max-block expiry, or when blocked or disabled.
// - Max-block timer expiry also drops active.
// - Settle needs current continuously below 0.9.
// - Selectable blocking input suppresses the function.
// - Running auto reclose blocks the function.
// - Indication only, never a trip command.
// - Undercurrent state is its own output.
package clp_pkg;
	localparam int         DATA_W      = 32;
	localparam int         ADDR_W      = 8;
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_UC_THR  = 8'h04;
	localparam logic [7:0] OFS_INR_THR = 8'h08;
	localparam logic [7:0] OFS_T_LOAD  = 8'h0C;
	localparam logic [7:0] OFS_T_SETL  = 8'h10;
	localparam logic [7:0] OFS_T_MAXB  = 8'h14;
	localparam logic [7:0] OFS_STATUS  = 8'h18;
	localparam logic [7:0] OFS_IRQ_ST  = 8'h1C;
	localparam logic [7:0] OFS_IRQ_MSK = 8'h20;
	localparam int         CTRL_EN     = 0;
	localparam int         CTRL_MODE   = 1;
	localparam int         CTRL_BLKEN  = 3;
	localparam int         CTRL_ARFIT  = 4;
	localparam logic [4:0] CTRL_RST    = 5'h00;
	localparam int         EV_ON       = 0;
	localparam int         EV_OFF      = 1;
	localparam int         EV_MAXB     = 2;
	localparam int         NUM_EV      = 3;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int         DROP_NUM    = 9;
	localparam int         DROP_DEN    = 10;
	typedef enum logic [1:0] {MODE_OPEN, MODE_UC, MODE_AND, MODE_OR} clp_mode_e;
	typedef enum logic [1:0] {S_WARM, S_LOADOFF, S_COLD, S_RECOVER} clp_state_e;
endpackage

// >>> hw/clp_tmr_if.sv
// Interface between the cold load pickup control and one tick timer.
`timescale 1ns/10ps
interface clp_tmr_if #(parameter int TW = 16);
	logic          tick;
	logic          clear;
	logic          start;
	logic [TW-1:0] limit;
	logic          running;
	logic          expired;
	modport timer (input tick, input clear, input start, input limit,
		output running, output expired);
	modport ctrl (output tick, output clear, output start, output limit,
		input running, input expired);
endinterface

// >>> hw/clp_timer.sv
// Tick counting timer of the cold load pickup block.
`timescale 1ns/10ps
module clp_timer #(
	parameter int TW = 16
) (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic ce,
	clp_tmr_if.timer  t
);
	logic [TW-1:0] count_r;
	logic          run_r;
	logic          exp_r;
	wire           hit = (count_r + 1'b1 >= t.limit);

	assign t.running = run_r;
	assign t.expired = exp_r;

	always_ff @(posedge clock)
	begin
		if (rst || (ce && t.clear))
		begin
			count_r <= '0;
			run_r   <= 1'b0;
			exp_r   <= 1'b0;
		end
		else if (ce && t.start)
		begin
			count_r <= '0;
			run_r   <= 1'b1;
			exp_r   <= 1'b0;
		end
		else if (ce && run_r && t.tick)
		begin
			count_r <= count_r + 1'b1;
			run_r   <= !hit;
			exp_r   <= hit;
		end
	end

	property p_restart;
		@(posedge clock) disable iff (rst)
		ce && t.start && !t.clear |=> count_r == '0 && run_r && !exp_r;
	endproperty
	a_restart: assert property (p_restart) else $error("Timer did not restart.");
endmodule

// >>> hw/clp_core.sv
// Cold load pickup logic with its AXI4-Lite register slave.
`timescale 1ns/10ps
module clp_core #(
	parameter int IW = 16,
	parameter int TW = 16
) (
	input  wire logic          clock,
	input  wire logic          rst,
	input  wire logic          ce,
	input  wire logic          sample_tick,
	input  wire logic          breaker_position,
	input  wire logic [IW-1:0] phase_a,
	input  wire logic [IW-1:0] phase_b,
	input  wire logic [IW-1:0] phase_c,
	input  wire logic          ext_block,
	input  wire logic          auto_reclose_running,
	output logic               cold_load_active,
	output logic               undercurrent_state,
	output logic               irq,
	input  wire logic [7:0]    s_awaddr,
	input  wire logic          s_awvalid,
	output logic               s_awready,
	input  wire logic [31:0]   s_wdata,
	input  wire logic [3:0]    s_wstrb,
	input  wire logic          s_wvalid,
	output logic               s_wready,
	output logic [1:0]         s_bresp,
	output logic               s_bvalid,
	input  wire logic          s_bready,
	input  wire logic [7:0]    s_araddr,
	input  wire logic          s_arvalid,
	output logic               s_arready,
	output logic [31:0]        s_rdata,
	output logic [1:0]         s_rresp,
	output logic               s_rvalid,
	input  wire logic          s_rready
);
	initial
	begin
		if (IW < 2 || IW > 24 || TW < 1 || TW > 32)
			$error("Unsupported current or timer width.");
	end

	// Registers written by software.
	logic [4:0]    ctrl_r;
	logic [IW-1:0] uc_thr_r;
	logic [IW-1:0] inr_thr_r;
	logic [TW-1:0] t_load_r;
	logic [TW-1:0] t_setl_r;
	logic [TW-1:0] t_maxb_r;
	logic [2:0]    irq_msk_r;
	logic [2:0]    irq_st_r;
	// Bus handshake state.
	logic [7:0]    awaddr_r;
	logic [31:0]   wdata_r;
	logic [3:0]    wstrb_r;
	logic          aw_got_r;
	logic          w_got_r;
	// Block state.
	clp_pkg::clp_state_e state_r;
	clp_pkg::clp_state_e state_nxt;
	logic          act_r;
	logic          uc_r;
	logic          inr_r;
	logic          b90_r;

	clp_tmr_if #(.TW(TW)) lo_t ();
	clp_tmr_if #(.TW(TW)) st_t ();
	clp_tmr_if #(.TW(TW)) mb_t ();

	clp_timer #(.TW(TW)) u_load (.clock(clock), .rst(rst), .ce(ce), .t(lo_t));
	clp_timer #(.TW(TW)) u_setl (.clock(clock), .rst(rst), .ce(ce), .t(st_t));
	clp_timer #(.TW(TW)) u_maxb (.clock(clock), .rst(rst), .ce(ce), .t(mb_t));

	// Measurement decode. Products are widened so the 90 percent test cannot wrap.
	wire [IW-1:0] max_ab  = (phase_a > phase_b) ? phase_a : phase_b;
	wire [IW-1:0] max_in  = (max_ab > phase_c) ? max_ab : phase_c;
	wire          uc_now  = (phase_a < uc_thr_r) && (phase_b < uc_thr_r)
		&& (phase_c < uc_thr_r);
	wire [IW+3:0] i_x10   = (IW+4)'(max_in) * (IW+4)'(clp_pkg::DROP_DEN);
	wire [IW+3:0] t_x9    = (IW+4)'(inr_thr_r) * (IW+4)'(clp_pkg::DROP_NUM);
	wire          b90_now = (i_x10 <= t_x9);
	wire          inr_hi  = (max_in > inr_thr_r);

	// Detection mode and blocking.
	wire [1:0] mode_w = ctrl_r[clp_pkg::CTRL_MODE +: 2];
	wire       cb_open = !breaker_position;
	logic      cold;
	always_comb
	begin
		case (clp_pkg::clp_mode_e'(mode_w))
			clp_pkg::MODE_OPEN: cold = cb_open;
			clp_pkg::MODE_UC:   cold = uc_r;
			clp_pkg::MODE_AND:  cold = cb_open && uc_r;
			clp_pkg::MODE_OR:   cold = cb_open || uc_r;
			default:            cold = 1'b0;
		endcase
	end
	wire ar_blk = ctrl_r[clp_pkg::CTRL_ARFIT] && auto_reclose_running;
	wire ex_blk = ctrl_r[clp_pkg::CTRL_BLKEN] && ext_block;
	wire blk    = !ctrl_r[clp_pkg::CTRL_EN] || ex_blk || ar_blk;

	// Timer control. A start outranks the clear that leaving a state implies.
	wire lo_go  = !blk && state_r == clp_pkg::S_WARM && cold;
	wire mb_go  = !blk && state_r == clp_pkg::S_COLD && !cold;
	wire in_rec = state_r == clp_pkg::S_RECOVER;
	wire st_go  = !blk && in_rec && !inr_r && b90_r && !st_t.running
		&& !st_t.expired;
	assign lo_t.tick  = sample_tick;
	assign st_t.tick  = sample_tick;
	assign mb_t.tick  = sample_tick;
	assign lo_t.limit = t_load_r;
	assign st_t.limit = t_setl_r;
	assign mb_t.limit = t_maxb_r;
	assign lo_t.start = lo_go;
	assign st_t.start = st_go;
	assign mb_t.start = mb_go;
	assign lo_t.clear = blk || (state_r != clp_pkg::S_LOADOFF && !lo_go);
	assign mb_t.clear = blk || (!in_rec && !mb_go);
	assign st_t.clear = blk || !in_rec || inr_r || !b90_r;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			clp_pkg::S_WARM:    if (lo_go) state_nxt = clp_pkg::S_LOADOFF;
			clp_pkg::S_LOADOFF:
			begin
				if (!cold)
					state_nxt = clp_pkg::S_WARM;
				else if (lo_t.expired)
					state_nxt = clp_pkg::S_COLD;
			end
			clp_pkg::S_COLD:    if (!cold) state_nxt = clp_pkg::S_RECOVER;
			clp_pkg::S_RECOVER:
			begin
				if (cold)
					state_nxt = clp_pkg::S_COLD;
				else if (st_t.expired || mb_t.expired)
					state_nxt = clp_pkg::S_WARM;
			end
			default:            state_nxt = clp_pkg::S_WARM;
		endcase
		if (blk)
			state_nxt = clp_pkg::S_WARM;
	end

	// The active flag is only an indication; nothing here can trip.
	wire act_nxt = (state_nxt == clp_pkg::S_COLD) || (state_nxt == clp_pkg::S_RECOVER);

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_r <= clp_pkg::S_WARM;
			act_r   <= 1'b0;
		end
		else if (ce)
		begin
			state_r <= state_nxt;
			act_r   <= act_nxt;
		end
	end

	// Measurements are taken on the protection tick only.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			uc_r   <= 1'b0;
			inr_r  <= 1'b0;
			b90_r  <= 1'b0;
		end
		else if (ce && sample_tick)
		begin
			uc_r   <= uc_now;
			b90_r  <= b90_now;
			if (!in_rec || inr_hi)
				inr_r <= inr_hi && in_rec;
			else if (b90_now)
				inr_r <= 1'b0;
		end
	end

	// Interrupt events; a new event wins over a clear in the same cycle.
	wire       wr_fire = aw_got_r && w_got_r && !s_bvalid;
	wire       wr_ist  = wr_fire && awaddr_r == clp_pkg::OFS_IRQ_ST && wstrb_r[0];
	wire [2:0] ev      = {mb_t.expired && in_rec && ce && !blk, act_r && !act_nxt,
		!act_r && act_nxt};
	wire [2:0] ist_nxt = (irq_st_r & ~(wr_ist ? wdata_r[2:0] : 3'h0)) | ev;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			irq_st_r <= 3'h0;
			irq      <= 1'b0;
		end
		else if (ce)
		begin
			irq_st_r <= ist_nxt;
			irq      <= |(ist_nxt & irq_msk_r);
		end
	end

	assign cold_load_active   = act_r;
	assign undercurrent_state = uc_r;

	// Register write path.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[8*i +: 8] = d[8*i +: 8];
		return r;
	endfunction

	wire [31:0] m_ctrl = merge(32'(ctrl_r), wdata_r, wstrb_r);
	wire [31:0] m_uc   = merge(32'(uc_thr_r), wdata_r, wstrb_r);
	wire [31:0] m_inr  = merge(32'(inr_thr_r), wdata_r, wstrb_r);
	wire [31:0] m_tlo  = merge(32'(t_load_r), wdata_r, wstrb_r);
	wire [31:0] m_tst  = merge(32'(t_setl_r), wdata_r, wstrb_r);
	wire [31:0] m_tmb  = merge(32'(t_maxb_r), wdata_r, wstrb_r);
	wire [31:0] m_msk  = merge(32'(irq_msk_r), wdata_r, wstrb_r);
	wire        wr_ok  = awaddr_r <= clp_pkg::OFS_IRQ_MSK && awaddr_r[1:0] == 2'h0
		&& awaddr_r != clp_pkg::OFS_STATUS;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ctrl_r    <= clp_pkg::CTRL_RST;
			uc_thr_r  <= '0;
			inr_thr_r <= '0;
			t_load_r  <= '0;
			t_setl_r  <= '0;
			t_maxb_r  <= '0;
			irq_msk_r <= 3'h0;
		end
		else if (ce && wr_fire)
		begin
			case (awaddr_r)
				clp_pkg::OFS_CTRL:    ctrl_r    <= m_ctrl[4:0];
				clp_pkg::OFS_UC_THR:  uc_thr_r  <= m_uc[IW-1:0];
				clp_pkg::OFS_INR_THR: inr_thr_r <= m_inr[IW-1:0];
				clp_pkg::OFS_T_LOAD:  t_load_r  <= m_tlo[TW-1:0];
				clp_pkg::OFS_T_SETL:  t_setl_r  <= m_tst[TW-1:0];
				clp_pkg::OFS_T_MAXB:  t_maxb_r  <= m_tmb[TW-1:0];
				clp_pkg::OFS_IRQ_MSK: irq_msk_r <= m_msk[2:0];
				default:              ctrl_r    <= ctrl_r;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			s_awready <= 1'b1;
			s_wready  <= 1'b1;
			s_bvalid  <= 1'b0;
			s_bresp   <= clp_pkg::RESP_OKAY;
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
		end
		else if (ce)
		begin
			if (s_awvalid && s_awready)
			begin
				awaddr_r  <= s_awaddr;
				aw_got_r  <= 1'b1;
				s_awready <= 1'b0;
			end
			if (s_wvalid && s_wready)
			begin
				wdata_r  <= s_wdata;
				wstrb_r  <= s_wstrb;
				w_got_r  <= 1'b1;
				s_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				s_bvalid <= 1'b1;
				s_bresp  <= wr_ok ? clp_pkg::RESP_OKAY : clp_pkg::RESP_SLVERR;
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
			end
			if (s_bvalid && s_bready)
			begin
				s_bvalid  <= 1'b0;
				s_awready <= 1'b1;
				s_wready  <= 1'b1;
			end
		end
	end

	// Register read path.
	wire [31:0] status_w = {26'h0, state_r, b90_r, inr_r, uc_r, act_r};
	logic [31:0] rd_w;
	logic        rd_ok;
	always_comb
	begin
		rd_ok = 1'b1;
		case (s_araddr)
			clp_pkg::OFS_CTRL:    rd_w = 32'(ctrl_r);
			clp_pkg::OFS_UC_THR:  rd_w = 32'(uc_thr_r);
			clp_pkg::OFS_INR_THR: rd_w = 32'(inr_thr_r);
			clp_pkg::OFS_T_LOAD:  rd_w = 32'(t_load_r);
			clp_pkg::OFS_T_SETL:  rd_w = 32'(t_setl_r);
			clp_pkg::OFS_T_MAXB:  rd_w = 32'(t_maxb_r);
			clp_pkg::OFS_STATUS:  rd_w = status_w;
			clp_pkg::OFS_IRQ_ST:  rd_w = 32'(irq_st_r);
			clp_pkg::OFS_IRQ_MSK: rd_w = 32'(irq_msk_r);
			default:
			begin
				rd_w  = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= clp_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_arvalid && s_arready)
			begin
				s_arready <= 1'b0;
				s_rvalid  <= 1'b1;
				s_rdata   <= rd_w;
				s_rresp   <= rd_ok ? clp_pkg::RESP_OKAY : clp_pkg::RESP_SLVERR;
			end
			else if (s_rvalid && s_rready)
			begin
				s_rvalid  <= 1'b0;
				s_arready <= 1'b1;
			end
		end
	end

	property p_loadoff_start;
		@(posedge clock) disable iff (rst)
		ce && lo_go |=> lo_t.running && state_r == clp_pkg::S_LOADOFF;
	endproperty
	a_loadoff_start: assert property (p_loadoff_start) else $error("No load-off start.");

	property p_active_on;
		@(posedge clock) disable iff (rst)
		ce && !blk && cold && state_r == clp_pkg::S_LOADOFF && lo_t.expired |=> act_r;
	endproperty
	a_active_on: assert property (p_active_on) else $error("Active not raised.");

	property p_block;
		@(posedge clock) disable iff (rst)
		ce && ex_blk |=> !act_r && state_r == clp_pkg::S_WARM && !mb_t.running;
	endproperty
	a_block: assert property (p_block) else $error("Block did not suppress.");

	property p_ar_block;
		@(posedge clock) disable iff (rst)
		ce && ar_blk |=> !act_r && !lo_t.running;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("Reclose did not block.");

	property p_undercurrent;
		@(posedge clock) disable iff (rst)
		ce && sample_tick |=> undercurrent_state == $past(uc_now);
	endproperty
	a_undercurrent: assert property (p_undercurrent) else $error("Bad undercurrent.");

	property p_settle_off;
		@(posedge clock) disable iff (rst)
		ce && !blk && in_rec && !cold && st_t.expired |=> !act_r ##1 !act_r || !ce;
	endproperty
	a_settle_off: assert property (p_settle_off) else $error("Settle did not release.");

	property p_maxblk_off;
		@(posedge clock) disable iff (rst)
		ce && !blk && in_rec && !cold && mb_t.expired && inr_r |=> !act_r && irq_st_r[2];
	endproperty
	a_maxblk_off: assert property (p_maxblk_off) else $error("Max-block ignored.");

	property p_settle_hold;
		@(posedge clock) disable iff (rst)
		ce && in_rec && !b90_r |=> !st_t.running && !st_t.expired;
	endproperty
	a_settle_hold: assert property (p_settle_hold) else $error("Settle ran above 0.9.");

	property p_inrush_set;
		@(posedge clock) disable iff (rst)
		ce && sample_tick && in_rec && inr_hi |=> inr_r;
	endproperty
	a_inrush_set: assert property (p_inrush_set) else $error("Inrush not detected.");
endmodule

// >>> verification/clp_feeder.sv
// Model of the breaker contact and the three phase current measurements.
`timescale 1ns/10ps
module clp_feeder #(
	parameter int IW = 16
) (
	input  wire logic          clock,
	input  wire logic          closed_cmd,
	input  wire logic [IW-1:0] load_cmd,
	output logic               breaker_position,
	output logic [IW-1:0]      phase_a,
	output logic [IW-1:0]      phase_b,
	output logic [IW-1:0]      phase_c
);
	int            seed = 3868;
	logic [IW-1:0] dip_b;
	logic [IW-1:0] dip_c;
	initial
	begin
		breaker_position = 1'b1;
		phase_a = '0;
		phase_b = '0;
		phase_c = '0;
	end
	// Phase a always carries the largest value, so a threshold acts on a
	// known phase; the other two wander slightly below it, as real
	// measurements do, which also tests that phases b and c below the threshold alone raise no undercurrent.
	always @(posedge clock)
	begin
		dip_b = IW'($random(seed) & 32'h3);
		dip_c = IW'($random(seed) & 32'h3);
		breaker_position <= closed_cmd;
		phase_a <= load_cmd;
		phase_b <= (load_cmd > dip_b) ? load_cmd - dip_b : load_cmd;
		phase_c <= (load_cmd > dip_c) ? load_cmd - dip_c : load_cmd;
	end
endmodule

// >>> verification/cold_load_pickup_logic_bench.sv
// Self-checking testbench of the cold load pickup block.
`timescale 1ns/10ps
module cold_load_pickup_logic_bench;
	typedef struct {string what; logic [33:0] val;} clp_note_s;
	localparam logic [15:0] LD_WARM = 16'h01F4;
	localparam logic [15:0] LD_INR  = 16'h07D0;
	localparam logic [15:0] LD_DROP = 16'h0384;
	localparam logic [15:0] LD_HI   = 16'h03B6;
	localparam logic [15:0] LD_LO   = 16'h0352;
	localparam logic [15:0] LD_UC   = 16'h0032;
	localparam logic [15:0] LD_UCT  = 16'h0064;
	logic        clock;
	logic        rst;
	logic        sample_tick = 1'b0;
	logic        closed_cmd;
	logic [15:0] load_cmd;
	logic        ext_block;
	logic        auto_reclose_running;
	logic        cold_load_active;
	logic        undercurrent_state;
	logic        irq;
	logic        breaker_position;
	logic [15:0] phase_a;
	logic [15:0] phase_b;
	logic [15:0] phase_c;
	logic [7:0]  s_awaddr;
	logic        s_awvalid;
	logic        s_awready;
	logic [31:0] s_wdata;
	logic        s_wvalid;
	logic        s_wready;
	logic [1:0]  s_bresp;
	logic        s_bvalid;
	logic        s_bready;
	logic [7:0]  s_araddr;
	logic        s_arvalid;
	logic        s_arready;
	logic [31:0] s_rdata;
	logic [1:0]  s_rresp;
	logic        s_rvalid;
	logic        s_rready;
	logic        probe_r;
	logic [33:0] seen;
	clp_note_s   cur;
	clp_note_s   notes[$];
	int          failures = 0;
	int          checks_done = 0;
	int          tick_cnt = 0;
	int          exp_act;

	clp_core #(.IW(16), .TW(16)) DUT (.clock(clock), .rst(rst), .ce(1'b1),
		.sample_tick(sample_tick), .breaker_position(breaker_position),
		.phase_a(phase_a), .phase_b(phase_b), .phase_c(phase_c),
		.ext_block(ext_block), .auto_reclose_running(auto_reclose_running),
		.cold_load_active(cold_load_active), .undercurrent_state(undercurrent_state),
		.irq(irq), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

	clp_feeder #(.IW(16)) feeder (.clock(clock), .closed_cmd(closed_cmd),
		.load_cmd(load_cmd), .breaker_position(breaker_position),
		.phase_a(phase_a), .phase_b(phase_b), .phase_c(phase_c));

	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// A protection tick every eight clocks keeps the timers short in cycles.
	always @(posedge clock)
	begin
		tick_cnt <= (tick_cnt == 7) ? 0 : tick_cnt + 1;
		sample_tick <= (tick_cnt == 7);
	end

	task automatic print_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		notes.push_back('{"bresp", {r, 32'h0}});
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_awready === 1'b1)
				s_awvalid <= 1'b0;
			if (s_wready === 1'b1)
				s_wvalid <= 1'b0;
		end
		while (s_bvalid !== 1'b1);
		s_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		notes.push_back('{"rdata", e});
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_arready === 1'b1)
				s_arvalid <= 1'b0;
		end
		while (s_rvalid !== 1'b1);
		s_rready <= 1'b0;
	endtask

	// Expected order of the bits is irq, undercurrent, active.
	task automatic probe(input logic [2:0] e);
		notes.push_back('{"outputs", {31'h0, e}});
		probe_r <= 1'b1;
		@(posedge clock);
		probe_r <= 1'b0;
		@(posedge clock);
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge sample_tick);
	endtask

	always @(posedge clock)
	begin
		if (((s_bvalid && s_bready) || (s_rvalid && s_rready) || probe_r) === 1'b1)
		begin
			seen = (s_bvalid === 1'b1) ? {s_bresp, 32'h0} : (s_rvalid === 1'b1) ?
				{s_rresp, s_rdata} : {31'h0, irq, undercurrent_state, cold_load_active};
			cur = notes.pop_front();
			checks_done++;
			if (seen !== cur.val)
			begin
				failures++;
				$display("BAD %s expected %h seen %h", cur.what, cur.val, seen);
			end
		end
	end

	initial
	begin
		repeat (30000) @(posedge clock);
		failures++;
		$display("watchdog expired");
		print_verdict;
	end

	initial
	begin
		rst = 1'b1;
		closed_cmd = 1'b1;
		load_cmd = LD_WARM;
		ext_block = 1'b0;
		auto_reclose_running = 1'b0;
		s_awaddr = 8'h00;
		s_awvalid = 1'b0;
		s_wdata = 32'h0;
		s_wvalid = 1'b0;
		s_bready = 1'b0;
		s_araddr = 8'h00;
		s_arvalid = 1'b0;
		s_rready = 1'b0;
		probe_r = 1'b0;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd(clp_pkg::OFS_CTRL, 34'h0);
		rd(clp_pkg::OFS_T_MAXB, 34'h0);
		rd(8'h40, {clp_pkg::RESP_SLVERR, 32'h0});
		wr(clp_pkg::OFS_STATUS, 32'h1, clp_pkg::RESP_SLVERR);
		wr(clp_pkg::OFS_UC_THR, 32'h64, clp_pkg::RESP_OKAY);
		wr(clp_pkg::OFS_INR_THR, 32'h3E8, clp_pkg::RESP_OKAY);
		wr(clp_pkg::OFS_T_LOAD, 32'h3, clp_pkg::RESP_OKAY);
		wr(clp_pkg::OFS_T_SETL, 32'h3, clp_pkg::RESP_OKAY);
		wr(clp_pkg::OFS_T_MAXB, 32'h10, clp_pkg::RESP_OKAY);
		wr(clp_pkg::OFS_IRQ_MSK, 32'h1, clp_pkg::RESP_OKAY);
		wr(clp_pkg::OFS_CTRL, 32'h1, clp_pkg::RESP_OKAY);
		rd(clp_pkg::OFS_T_LOAD, 34'h3);
		$display("test registers done");
		closed_cmd <= 1'b0;
		ticks(1);
		probe(3'b000);
		ticks(6);
		probe(3'b101);
		rd(clp_pkg::OFS_IRQ_ST, 34'h1);
		wr(clp_pkg::OFS_IRQ_ST, 32'h1, clp_pkg::RESP_OKAY);
		rd(clp_pkg::OFS_IRQ_ST, 34'h0);
		probe(3'b001);
		wr(clp_pkg::OFS_IRQ_MSK, 32'h0, clp_pkg::RESP_OKAY);
		$display("test load-off done");
		closed_cmd <= 1'b1;
		load_cmd <= LD_INR;
		ticks(8);
		probe(3'b001);
		load_cmd <= LD_DROP;
		ticks(1);
		probe(3'b001);
		ticks(6);
		probe(3'b000);
		$display("test inrush done");
		closed_cmd <= 1'b0;
		load_cmd <= LD_WARM;
		ticks(6);
		probe(3'b001);
		wr(clp_pkg::OFS_IRQ_ST, 32'h7, clp_pkg::RESP_OKAY);
		closed_cmd <= 1'b1;
		// Crossing the dropout level every tick keeps the settle timer restarting.
		repeat (12)
		begin
			load_cmd <= (load_cmd == LD_LO) ? LD_HI : LD_LO;
			ticks(1);
		end
		probe(3'b001);
		repeat (8)
		begin
			load_cmd <= (load_cmd == LD_LO) ? LD_HI : LD_LO;
			ticks(1);
		end
		probe(3'b000);
		rd(clp_pkg::OFS_IRQ_ST, 34'h6);
		wr(clp_pkg::OFS_IRQ_MSK, 32'h4, clp_pkg::RESP_OKAY);
		probe(3'b100);
		wr(clp_pkg::OFS_IRQ_ST, 32'h4, clp_pkg::RESP_OKAY);
		probe(3'b000);
		$display("test max-block done");
		load_cmd <= LD_WARM;
		wr(clp_pkg::OFS_CTRL, 32'h19, clp_pkg::RESP_OKAY);
		closed_cmd <= 1'b0;
		ticks(6);
		probe(3'b001);
		ext_block <= 1'b1;
		ticks(1);
		probe(3'b000);
		ext_block <= 1'b0;
		ticks(1);
		probe(3'b000);
		ticks(6);
		probe(3'b001);
		auto_reclose_running <= 1'b1;
		ticks(1);
		probe(3'b000);
		auto_reclose_running <= 1'b0;
		ticks(6);
		probe(3'b001);
		wr(clp_pkg::OFS_CTRL, 32'h1, clp_pkg::RESP_OKAY);
		ext_block <= 1'b1;
		auto_reclose_running <= 1'b1;
		ticks(2);
		probe(3'b001);
		ext_block <= 1'b0;
		auto_reclose_running <= 1'b0;
		closed_cmd <= 1'b1;
		ticks(6);
		probe(3'b000);
		$display("test blocking done");
		for (int m = 0; m < 4; m++)
		begin
			wr(clp_pkg::OFS_CTRL, 32'(m * 2 + 1), clp_pkg::RESP_OKAY);
			for (int j = 0; j < 3; j++)
			begin
				// The first case sits exactly on the undercurrent threshold.
				closed_cmd <= (j == 1);
				load_cmd <= (j == 0) ? LD_UCT : LD_UC;
				exp_act = (j == 2) || ((j == 0) ? (m == 0 || m == 3) : (m == 1 || m == 3));
				ticks(6);
				probe({1'b0, j != 0, exp_act != 0});
				closed_cmd <= 1'b1;
				load_cmd <= LD_WARM;
				ticks(6);
				probe(3'b000);
			end
		end
		$display("test modes done");
		print_verdict;
	end
endmodule
